// File: design/insn_decoder.sv
// Purpose: Decoder for bit, control, literal and table instruction groups.
// Assumes: One fetched word per cycle; datapath supplies flags and tested bit.
// Notes: All outputs come from the registered state.
// How it works
// - Bit clear/set/toggle read-modify-write; port targets read pins.
// - Skip-if-clear 1011, skip-if-set 1010, bit index, access bit, address.
// - True skip or one-word PC change takes two cycles, second is a nop.
// - Conditional branches on eight flag tests; unconditional branch 11-bit offset.
// - Absolute call is two words; relative call takes two cycles.
// - Absolute jump is two words carrying twenty address bits.
// - Stray 1111 words execute as nop unless consumed as second word.
// - Nop, watchdog clear, standby and software reset control words.
// - Pop and push of the return stack leave flags alone.
// - Interrupt and subroutine returns take two cycles; interrupt return sets enables.
// - Return-with-literal loads the working register and returns in two cycles.
// - Add and subtract literal update all five arithmetic flags.
// - Literal and/or/xor update only zero and negative.
// - Load and multiply literal alter no flags.
// - Bank literal loads the bank select register low nibble.
// - Pointer load writes a 12-bit literal into the chosen file pointer.
// - Table reads with four pointer-update modes, two cycles.
// - Table writes with the same four modes, two cycles.
// - Writes to the timer-zero count clear its prescaler.
// - Access bit 0 selects access bank, 1 uses bank select register.
module insn_decoder
   import insn_dec_pkg::*;
#(
   parameter int AW = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [4:0] flags_in,
   input wire logic tested_bit,
   input wire logic target_is_port,
   input wire logic target_is_timer0,
   output dec_t dec,
   input wire logic [AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   if (AW < 4 || AW > 8) begin : g_chk
      $error("AW must lie between 4 and 8");
   end

   state_t s, next_s;
   logic [15:0] w;
   logic [3:0] top;
   logic [7:0] rd_addr;

   // Effective file address from access bit, offset and bank
   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] fa, input logic [3:0] bank_select_register);
      if (a) begin
         return {bank_select_register, fa};
      end
      return {(fa < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, fa};
   endfunction

   // Branch condition: code[2:1] picks the flag, code[0] inverts
   function automatic logic cond_true(input logic [2:0] code, input logic [4:0] fl);
      logic v;
      case (code[2:1])
         2'h0: v = fl[FLG_Z];
         2'h1: v = fl[FLG_C];
         2'h2: v = fl[FLG_OV];
         default: v = fl[FLG_N];
      endcase
      return v ^ code[0];
   endfunction

   // Decode and register-slave next state
   always_comb begin
      next_s = s;
      w = instr_word;
      top = instr_word[15:12];
      rd_addr = 8'(araddr);
      next_s.dec = '0; // Flags untouched unless a group names them
      if (instr_valid) begin
         next_s.dec.valid = 1'b1;
         next_s.count = s.count + 16'h0001;
         if (s.halt) begin
            next_s.dec.nop = 1'b1;
            next_s.phase = PH_RUN;
         end else if (s.phase == PH_FLUSH) begin
            next_s.dec.nop = 1'b1;
            next_s.phase = PH_RUN;
         end else if (s.phase == PH_WORD2) begin
            // Second word completes the held first word
            next_s.phase = PH_RUN;
            next_s.dec.target = {w[11:0], s.first[7:0]};
            if (s.first[15:8] == HI_JUMP) begin
               next_s.dec.abs_jump = 1'b1;
            end else if (s.first[15:8] == HI_PTR) begin
               next_s.dec.ptr_load = 1'b1;
               next_s.dec.ptr_sel = s.first[5:4];
               next_s.dec.ptr_val = {s.first[3:0], w[7:0]};
            end else begin
               next_s.dec.call = 1'b1;
               next_s.dec.push = 1'b1;
               next_s.dec.shadow = s.first[8];
            end
         end else if (top == NIB_BIT_CLR || top == NIB_BIT_SET || top == NIB_BIT_TOG) begin
            next_s.dec.bit_op = 1'b1;
            next_s.dec.bit_sel = w[11:9];
            next_s.dec.file_addr = file_addr(w[8], w[7:0], s.bank);
            next_s.dec.read_pins = target_is_port;
            next_s.dec.clr_prescaler = target_is_timer0;
            if (top == NIB_BIT_CLR) begin
               next_s.dec.bit_kind = BK_CLR;
            end else if (top == NIB_BIT_SET) begin
               next_s.dec.bit_kind = BK_SET;
            end else begin
               next_s.dec.bit_kind = BK_TOG;
            end
         end else if (top == NIB_SKIP_CLR || top == NIB_SKIP_SET) begin
            next_s.dec.bit_sel = w[11:9];
            next_s.dec.file_addr = file_addr(w[8], w[7:0], s.bank);
            next_s.dec.skip = (top == NIB_SKIP_CLR) ? !tested_bit : tested_bit;
            if (next_s.dec.skip) begin
               next_s.phase = PH_FLUSH;
            end
         end else if (w[15:11] == PFX_COND_BR) begin
            next_s.dec.rel_off = {{3{w[7]}}, w[7:0]};
            next_s.dec.branch_taken = cond_true(w[10:8], flags_in);
            if (next_s.dec.branch_taken) begin
               next_s.phase = PH_FLUSH;
            end
         end else if (w[15:11] == PFX_REL_JUMP) begin
            next_s.dec.rel_off = w[10:0];
            next_s.dec.branch_taken = 1'b1;
            next_s.phase = PH_FLUSH;
         end else if (w[15:11] == PFX_REL_CALL) begin
            next_s.dec.rel_off = w[10:0];
            next_s.dec.call = 1'b1;
            next_s.dec.push = 1'b1;
            next_s.phase = PH_FLUSH;
         end else if (w[15:9] == HI_CALL || w[15:8] == HI_JUMP || w[15:8] == HI_PTR) begin
            // Hold the first word; nothing issues until the second arrives
            next_s.dec.valid = 1'b0;
            next_s.first = w;
            next_s.phase = PH_WORD2;
         end else if (top == NIB_SECOND) begin
            next_s.dec.nop = 1'b1;
         end else if (w[15:8] == HI_ADD || w[15:8] == HI_SUB) begin
            next_s.dec.alu = (w[15:8] == HI_ADD) ? ALU_ADD : ALU_SUB;
            next_s.dec.literal = w[7:0];
            next_s.dec.flag_mask = MASK_ARITH;
         end else if (w[15:8] == HI_AND || w[15:8] == HI_OR || w[15:8] == HI_XOR) begin
            next_s.dec.literal = w[7:0];
            next_s.dec.flag_mask = MASK_LOGIC;
            if (w[15:8] == HI_AND) begin
               next_s.dec.alu = ALU_AND;
            end else if (w[15:8] == HI_OR) begin
               next_s.dec.alu = ALU_OR;
            end else begin
               next_s.dec.alu = ALU_XOR;
            end
         end else if (w[15:8] == HI_MOV || w[15:8] == HI_MUL) begin
            next_s.dec.alu = (w[15:8] == HI_MOV) ? ALU_MOV : ALU_MUL;
            next_s.dec.literal = w[7:0];
         end else if (w[15:8] == HI_RET_LIT) begin
            next_s.dec.alu = ALU_MOV;
            next_s.dec.literal = w[7:0];
            next_s.dec.ret = 1'b1;
            next_s.dec.pop = 1'b1;
            next_s.phase = PH_FLUSH;
         end else if (w[15:4] == HI_BANK) begin
            next_s.dec.bank_load = 1'b1;
            next_s.bank = w[3:0];
         end else if (w[15:1] == W_RET_IRQ || w[15:1] == W_RET) begin
            next_s.dec.ret = 1'b1;
            next_s.dec.pop = 1'b1;
            next_s.dec.shadow = w[0];
            next_s.dec.set_irq_en = (w[15:1] == W_RET_IRQ);
            next_s.phase = PH_FLUSH;
         end else if (w[15:3] == W_TABLE) begin
            next_s.dec.tbl_rd = !w[2];
            next_s.dec.tbl_wt = w[2];
            next_s.dec.tbl_mode = w[1:0];
            next_s.phase = PH_FLUSH;
         end else if (w == W_SLEEP) begin
            next_s.dec.sleep = 1'b1;
         end else if (w == W_WDT) begin
            next_s.dec.wdt_clear = 1'b1;
         end else if (w == W_PUSH) begin
            next_s.dec.push = 1'b1;
         end else if (w == W_POP) begin
            next_s.dec.pop = 1'b1;
         end else if (w == W_DAW) begin
            next_s.dec.decimal_adjust = 1'b1;
            next_s.dec.flag_mask = MASK_CARRY;
         end else if (w == W_RESET) begin
            next_s.dec.soft_reset = 1'b1;
            next_s.dec.flag_mask = MASK_ARITH;
            next_s.bank = 4'h0;
         end else begin
            next_s.dec.nop = 1'b1;
         end
      end

      // Write channel: address and data taken in either order
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (awvalid && s.awready) begin
         next_s.awaddr = 8'(awaddr);
         next_s.aw_got = 1'b1;
      end
      if (wvalid && s.wready) begin
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
         next_s.w_got = 1'b1;
      end
      if (next_s.aw_got && next_s.w_got && !next_s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         if (next_s.awaddr == REG_CTRL) begin
            if (next_s.wstrb[0]) begin
               next_s.halt = next_s.wdata[CTRL_HALT_BIT];
            end
         end else if (next_s.awaddr == REG_COUNT) begin
            next_s.count = 16'h0000; // Any write clears the counter
         end else if (next_s.awaddr != REG_STATUS) begin
            next_s.bresp = RESP_SLVERR;
         end
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      // Read channel: one read outstanding
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         if (rd_addr == REG_CTRL) begin
            next_s.rdata = 32'(s.halt) << CTRL_HALT_BIT;
         end else if (rd_addr == REG_STATUS) begin
            next_s.rdata = 32'(s.phase) | (32'(s.bank) << STAT_BANK_LSB);
         end else if (rd_addr == REG_COUNT) begin
            next_s.rdata = 32'(s.count);
         end else begin
            next_s.rdata = 32'h0000_0000;
            next_s.rresp = RESP_SLVERR;
         end
      end
      next_s.arready = !next_s.rvalid;
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state
   assign dec = s.dec;
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Named steps that the properties below build on
   sequence run_word;
      instr_valid && !s.halt && s.phase == PH_RUN;
   endsequence
   sequence first_of_call;
      run_word and (instr_word[15:9] == HI_CALL);
   endsequence
   sequence call_completes;
      s.phase == PH_WORD2 && instr_valid && !s.halt && s.first[15:9] == HI_CALL;
   endsequence

   a_bit_clear_rmw: assert property (run_word and (instr_word[15:12] == NIB_BIT_CLR) |=>
      dec.bit_op && dec.bit_kind == BK_CLR && dec.read_pins == $past(target_is_port) && dec.flag_mask == MASK_NONE)
      else $error("bit clear not decoded as rmw");
   a_skip_clear_flush: assert property (run_word and (instr_word[15:12] == NIB_SKIP_CLR) && !tested_bit |=>
      (dec.skip && s.phase == PH_FLUSH) and (instr_valid |=> dec.nop))
      else $error("skip on clear bit missing or not followed by nop");
   a_flush_nop: assert property (instr_valid && s.phase == PH_FLUSH |=> dec.valid && dec.nop && s.phase == PH_RUN)
      else $error("second cycle of two-cycle instruction not a nop");
   a_branch_zero: assert property (run_word and (instr_word[15:8] == {PFX_COND_BR, 3'h0}) && flags_in[FLG_Z] |=>
      dec.branch_taken && dec.rel_off == {{3{$past(instr_word[7])}}, $past(instr_word[7:0])})
      else $error("branch on zero not taken with sign-extended offset");
   a_call_held: assert property (first_of_call |=> !dec.valid && s.phase == PH_WORD2)
      else $error("call first word not held");
   a_call_target: assert property (call_completes |=> dec.call && dec.push &&
      dec.target == {$past(instr_word[11:0]), $past(s.first[7:0])})
      else $error("call target not assembled from both words");
   a_stray_second: assert property (run_word and (instr_word[15:12] == NIB_SECOND) |=> dec.nop && !dec.call)
      else $error("stray second word not executed as nop");
   a_irq_return: assert property (run_word and (instr_word[15:1] == W_RET_IRQ) |=>
      dec.ret && dec.set_irq_en && dec.flag_mask == MASK_NONE && s.phase == PH_FLUSH)
      else $error("interrupt return does not set enables over two cycles");
   a_add_flags: assert property (run_word and (instr_word[15:8] == HI_ADD) |=> dec.alu == ALU_ADD &&
      dec.flag_mask == MASK_ARITH && dec.literal == $past(instr_word[7:0]))
      else $error("add literal flags wrong");
   a_logic_flags: assert property (run_word and (instr_word[15:8] == HI_XOR) |=> dec.flag_mask == MASK_LOGIC)
      else $error("xor literal flags wrong");
   a_bank_access: assert property (run_word and (instr_word[15:4] == HI_BANK) |=> s.bank == $past(instr_word[3:0]))
      else $error("bank select not loaded");
   a_bank_used: assert property (run_word and (instr_word[15:12] == NIB_BIT_SET) && instr_word[8] |=>
      dec.file_addr == {$past(s.bank), $past(instr_word[7:0])})
      else $error("banked address not built from bank select");
   a_table_flush: assert property (run_word and (instr_word[15:3] == W_TABLE) |=>
      (dec.tbl_wt == $past(instr_word[2])) && (dec.tbl_rd != dec.tbl_wt) && s.phase == PH_FLUSH)
      else $error("table access not two cycles");
   a_prescaler: assert property (run_word and (instr_word[15:12] == NIB_BIT_TOG) && target_is_timer0 |=>
      dec.clr_prescaler)
      else $error("prescaler not cleared on timer write");
endmodule

// File: shared/insn_dec_pkg.sv
// Purpose: Constants and carrier types for the instruction decoder.
// Assumes: 16-bit instruction words, 8-bit data path, AXI4-Lite registers.
// Notes: Opcode patterns are grouped by the field they are compared against.
package insn_dec_pkg;
   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam int CTRL_HALT_BIT = 0;
   localparam int STAT_BANK_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Top nibbles
   localparam logic [3:0] NIB_BIT_CLR = 4'h9;
   localparam logic [3:0] NIB_BIT_SET = 4'h8;
   localparam logic [3:0] NIB_BIT_TOG = 4'h7;
   localparam logic [3:0] NIB_SKIP_CLR = 4'hb;
   localparam logic [3:0] NIB_SKIP_SET = 4'ha;
   localparam logic [3:0] NIB_SECOND = 4'hf;
   // Five-bit prefixes
   localparam logic [4:0] PFX_COND_BR = 5'h1c;
   localparam logic [4:0] PFX_REL_JUMP = 5'h1a;
   localparam logic [4:0] PFX_REL_CALL = 5'h1b;
   // First words of two-word instructions
   localparam logic [6:0] HI_CALL = 7'h76;
   localparam logic [7:0] HI_JUMP = 8'hef;
   localparam logic [7:0] HI_PTR = 8'hee;
   // Literal group, upper byte; bank literal upper twelve bits
   localparam logic [7:0] HI_ADD = 8'h0f;
   localparam logic [7:0] HI_SUB = 8'h08;
   localparam logic [7:0] HI_AND = 8'h0b;
   localparam logic [7:0] HI_OR = 8'h09;
   localparam logic [7:0] HI_XOR = 8'h0a;
   localparam logic [7:0] HI_MOV = 8'h0e;
   localparam logic [7:0] HI_MUL = 8'h0d;
   localparam logic [7:0] HI_RET_LIT = 8'h0c;
   localparam logic [11:0] HI_BANK = 12'h010;
   // Whole control words and partial patterns
   localparam logic [15:0] W_NOP = 16'h0000;
   localparam logic [15:0] W_SLEEP = 16'h0003;
   localparam logic [15:0] W_WDT = 16'h0004;
   localparam logic [15:0] W_PUSH = 16'h0005;
   localparam logic [15:0] W_POP = 16'h0006;
   localparam logic [15:0] W_DAW = 16'h0007;
   localparam logic [15:0] W_RESET = 16'h00ff;
   localparam logic [14:0] W_RET_IRQ = 15'h0008;
   localparam logic [14:0] W_RET = 15'h0009;
   localparam logic [12:0] W_TABLE = 13'h0001;
   // Flag positions and update masks {n, ov, z, dc, c}
   localparam int FLG_C = 0;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   localparam logic [4:0] MASK_NONE = 5'h00;
   localparam logic [4:0] MASK_ARITH = 5'h1f;
   localparam logic [4:0] MASK_LOGIC = 5'h14;
   localparam logic [4:0] MASK_CARRY = 5'h01;
   // Access bank split
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

   typedef enum logic [1:0] {PH_RUN, PH_WORD2, PH_FLUSH} phase_t;
   typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV, ALU_MUL} alu_t;
   typedef enum logic [1:0] {BK_CLR, BK_SET, BK_TOG} bit_kind_t;

   // Decoded instruction handed to the datapath
   typedef struct packed {
      logic valid;
      logic nop;
      logic bit_op;
      bit_kind_t bit_kind;
      logic [2:0] bit_sel;
      logic read_pins;
      logic clr_prescaler;
      logic [11:0] file_addr;
      logic skip;
      logic branch_taken;
      logic [10:0] rel_off;
      logic abs_jump;
      logic call;
      logic [19:0] target;
      logic shadow;
      logic push;
      logic pop;
      logic ret;
      logic set_irq_en;
      alu_t alu;
      logic [7:0] literal;
      logic [4:0] flag_mask;
      logic wdt_clear;
      logic sleep;
      logic soft_reset;
      logic decimal_adjust;
      logic bank_load;
      logic ptr_load;
      logic [1:0] ptr_sel;
      logic [11:0] ptr_val;
      logic tbl_rd;
      logic tbl_wt;
      logic [1:0] tbl_mode;
   } dec_t;

   // Whole state of the decoder and its register slave
   typedef struct packed {
      phase_t phase;
      logic [15:0] first;
      logic [3:0] bank;
      logic [15:0] count;
      logic halt;
      dec_t dec;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;
endpackage

// File: tb/fetch_model.sv
// Purpose: Program memory fetch and datapath stand-in feeding the decoder.
// Assumes: Each requested word reaches the decoder one cycle after go.
// Notes: Idle cycles drive inverted values so no stale word looks valid.
module fetch_model
   import insn_dec_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic [15:0] word_in,
   input wire logic [4:0] fl_in,
   input wire logic [2:0] side_in,
   output logic instr_valid,
   output logic [15:0] instr_word,
   output logic [4:0] flags_in,
   output logic tested_bit,
   output logic target_is_port,
   output logic target_is_timer0
);
   timeunit 1ns;
   timeprecision 100ps;
   // One word per cycle, datapath answers sampled with it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_valid <= 1'b0;
         instr_word <= 16'h0000;
         flags_in <= 5'h00;
         {target_is_timer0, target_is_port, tested_bit} <= 3'h0;
      end else begin
         instr_valid <= go;
         instr_word <= go ? word_in : ~instr_word;
         flags_in <= go ? fl_in : ~flags_in;
         {target_is_timer0, target_is_port, tested_bit} <= go ? side_in : ~{target_is_timer0, target_is_port, tested_bit};
      end
   end
endmodule

// File: tb/bit_control_literal_table_decoder_test.sv
// Purpose: Self-checking bench for the instruction decoder.
// Assumes: Fetch model adds one cycle; decode shows one cycle later.
// Notes: AXI tasks hold each valid until its ready.
module bit_control_literal_table_decoder_test import insn_dec_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
   logic [15:0] word_in = 16'h0000, instr_word;
   logic [4:0] fl_in = 5'h00, flags_in;
   logic [2:0] side_in = 3'h0;
   logic instr_valid, tested_bit, target_is_port, target_is_timer0;
   dec_t dec;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   int err_total = 0, comparisons = 0;
   localparam logic [7:0] LHI [7] = '{HI_ADD, HI_SUB, HI_AND, HI_OR, HI_XOR, HI_MOV, HI_MUL};
   localparam alu_t LALU [7] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV, ALU_MUL};
   localparam logic [4:0] LMSK [7] = '{MASK_ARITH, MASK_ARITH, MASK_LOGIC, MASK_LOGIC, MASK_LOGIC, MASK_NONE, MASK_NONE};

   fetch_model pm(.aclk, .aresetn, .go, .word_in, .fl_in, .side_in, .instr_valid, .instr_word, .flags_in,
      .tested_bit, .target_is_port, .target_is_timer0);
   insn_decoder dut(.aclk, .aresetn, .instr_valid, .instr_word, .flags_in, .tested_bit, .target_is_port,
      .target_is_timer0, .dec, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready);

   // Free-running core clock
   initial begin
      forever #2.5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic [15:0] w, input logic [4:0] f = 5'h00, input logic [2:0] s = 3'h0);
      @(posedge aclk);
      go <= 1'b1;
      word_in <= w;
      fl_in <= f;
      side_in <= s;
   endtask
   // One word, then look at its decode
   task automatic one(input logic [15:0] w, input logic [4:0] f = 5'h00, input logic [2:0] s = 3'h0);
      put(w, f, s);
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
      #1;
   endtask
   // Word after a two-cycle instruction
   task automatic fill(input logic e);
      one(16'h0e01);
      chk(dec.nop, e);
   endtask
   task automatic pair(input logic [15:0] w1, input logic [15:0] w2);
      put(w1);
      put(w2);
      @(posedge aclk);
      go <= 1'b0;
      #1;
      chk(dec.valid, 1'b0);
      @(posedge aclk);
      #1;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a[3:0];
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a[3:0];
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic final_report();
      $display("mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      #20000;
      err_total++;
      final_report();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 7; i++) begin
         one({LHI[i], 8'h5a});
         chk(dec.alu, LALU[i]);
         chk(dec.literal, 8'h5a);
         chk(dec.flag_mask, LMSK[i]);
      end
      one(16'h0107);
      chk(dec.bank_load, 1'b1);
      one(16'h9a23, 5'h00, 3'h6);
      chk({dec.bit_op, dec.bit_kind, dec.bit_sel}, {1'b1, BK_CLR, 3'h5});
      chk({dec.read_pins, dec.clr_prescaler}, 2'h3);
      chk(dec.file_addr, 12'h023);
      chk(dec.flag_mask, MASK_NONE);
      one(16'h8b85);
      chk({dec.bit_kind, dec.read_pins, dec.file_addr}, {BK_SET, 1'b0, 12'h785});
      one(16'h7290);
      chk({dec.bit_kind, dec.bit_sel, dec.file_addr}, {BK_TOG, 3'h1, 12'hf90});
      axr(REG_STATUS);
      chk(rd, 32'h70);
      one(16'hb010);
      chk(dec.skip, 1'b1);
      fill(1'b1);
      one(16'ha010);
      chk({dec.skip, dec.flag_mask}, 6'h00);
      for (int c = 0; c < 8; c++) begin
         one({PFX_COND_BR, c[2:0], 8'hfe}, 5'h1d);
         chk(dec.branch_taken, !c[0]);
         if (!c[0]) chk(dec.rel_off, 11'h7fe);
         fill(!c[0]);
      end
      one(16'hd805);
      chk(dec.push, 1'b1);
      fill(1'b1);
      pair(16'hec12, 16'hf345);
      chk({dec.call, dec.push, dec.target}, {2'h3, 20'h34512});
      pair(16'hef34, 16'hf567);
      chk({dec.abs_jump, dec.flag_mask, dec.target}, {1'b1, MASK_NONE, 20'h56734});
      pair(16'hee25, 16'hf0ab);
      chk({dec.ptr_load, dec.ptr_sel, dec.ptr_val}, {3'h6, 12'h5ab});
      one(16'hf123);
      chk(dec.nop, 1'b1);
      one(W_WDT);
      chk(dec.wdt_clear, 1'b1);
      one(W_SLEEP);
      chk(dec.sleep, 1'b1);
      one(W_PUSH);
      chk({dec.push, dec.flag_mask}, 6'h20);
      one(W_POP);
      chk({dec.pop, dec.flag_mask}, 6'h20);
      one(16'h0011);
      chk({dec.ret, dec.set_irq_en, dec.shadow}, 3'h7);
      fill(1'b1);
      one(16'h0012);
      chk({dec.ret, dec.set_irq_en, dec.shadow}, 3'h4);
      fill(1'b1);
      one(16'h0c44);
      chk({dec.ret, dec.literal, dec.flag_mask}, {1'b1, 8'h44, MASK_NONE});
      fill(1'b1);
      for (int m = 0; m < 8; m++) begin
         one({12'h000, 1'b1, m[2:0]});
         chk({dec.tbl_rd, dec.tbl_wt, dec.tbl_mode}, {!m[2], m[2], m[1:0]});
         fill(1'b1);
      end
      one(W_DAW);
      chk({dec.decimal_adjust, dec.flag_mask}, {1'b1, MASK_CARRY});
      one(W_RESET);
      chk({dec.soft_reset, dec.flag_mask}, 6'h3f);
      axr(REG_STATUS);
      chk(rd, 32'h0);
      axw(REG_CTRL, 32'h1);
      chk(resp, RESP_OKAY);
      one(16'h0f05);
      chk(dec.nop, 1'b1);
      axw(REG_CTRL, 32'h0);
      axw(REG_COUNT, 32'h0);
      repeat (3) one(16'h0e01);
      axr(REG_COUNT);
      chk(rd, 32'h3);
      axr(8'h0c);
      chk(resp, RESP_SLVERR);
      chk(rd, 32'h0);
      axw(8'h0c, 32'h1);
      chk(resp, RESP_SLVERR);
      final_report();
   end
endmodule
